// ---- rtl/tmr8_cfg.svh ----
// What this block does
// - Nonzero compare output mode routes the compare output state to the pin.
// - Pin direction stays under the port direction bit during override.
// - Override works in every waveform mode; state can be set before enabling pin.
// - Compare output mode zero leaves the compare output state untouched on match.
// - A new compare output mode acts from the first match after the write.
// - Force strobe applies the selected action at once in non-PWM modes.
// - Waveform mode sets counting; compare output mode sets only output action.
// - Normal mode always increments and wraps from 0xff to 0x00.
// - Normal mode sets overflow flag as counter becomes zero; never clears it.
// - Clear-on-match mode clears counter on compare match.
// - Clear-on-match compare value is unbuffered; below count means wrap first.
// - Clear-on-match with mode one toggles the output on every match.
// - Clear-on-match sets overflow flag when counter steps from max to zero.
// - Fast PWM counts up from zero to max and restarts, single slope.
// - Fast PWM clears the counter on the tick after it equals max.
// - Fast PWM mode two clears on match, sets at bottom; mode three inverse.
// - Fast PWM sets the overflow flag each time the counter steps from max to zero.
// - Fast PWM compare zero gives one-tick spike; compare max gives constant level.
// - Fast PWM mode one toggles on match; compare value still buffered.
// - PWM modes buffer compare writes until top; non-PWM writes go direct.
// - A match sets the compare flag on the next timer tick.
// - Forced compare changes output only; no flag, no counter clear or reload.
// - A counter write blocks any match on the next timer tick.
//
// Register offsets, field positions and reset values of the timer.
// Assumes a 32-bit APB slave with byte addresses on paddr.
`ifndef TMR8_CFG_SVH
`define TMR8_CFG_SVH

`define TMR8_OFF_CTRL 8'h00
`define TMR8_OFF_COUNT 8'h04
`define TMR8_OFF_COMPARE 8'h08
`define TMR8_OFF_FLAGS 8'h0c
`define TMR8_OFF_PORT 8'h10

`define TMR8_CTRL_WMODE_LSB 0
`define TMR8_CTRL_COM_LSB 2
`define TMR8_CTRL_FORCE_BIT 4
`define TMR8_FLAGS_OVF_BIT 0
`define TMR8_FLAGS_CMP_BIT 1
`define TMR8_PORT_VAL_BIT 0
`define TMR8_PORT_DIR_BIT 1
`define TMR8_PORT_OC_BIT 2

`define TMR8_MAX 8'hff
`define TMR8_BOTTOM 8'h00
`define TMR8_RST_COUNT 8'h00
`define TMR8_RST_COMPARE 8'h00

`endif

// ---- rtl/tmr8_pkg.sv ----
// Types shared by the timer files.
// Assumes nothing of its surroundings.
package tmr8_pkg;
  typedef enum logic [1:0] {
    TMR8_NORMAL = 2'b00,
    TMR8_PHASE = 2'b01,
    TMR8_CTC = 2'b10,
    TMR8_FAST = 2'b11
  } tmr8_wave_t;

  typedef enum logic [1:0] {
    TMR8_COM_OFF = 2'b00,
    TMR8_COM_TOGGLE = 2'b01,
    TMR8_COM_CLEAR = 2'b10,
    TMR8_COM_SET = 2'b11
  } tmr8_com_t;
endpackage : tmr8_pkg

// ---- rtl/tmr8_pin_mux.sv ----
// Port pin override: picks the compare output state or the port value.
// Assumes all inputs come from registers on pclk.
module tmr8_pin_mux (
  input wire logic pclk,
  input wire logic presetn,
  input wire tmr8_pkg::tmr8_com_t compare_output_mode,
  input wire logic compare_output_state,
  input wire logic port_value,
  input wire logic pin_direction_bit,
  output logic pin_out,
  output logic pin_oe
);
  logic next_pin_out;
  logic next_pin_oe;

  always_comb begin
    // Override holds whatever the waveform mode is
    next_pin_out = (compare_output_mode != tmr8_pkg::TMR8_COM_OFF) ? compare_output_state : port_value;
    next_pin_oe = pin_direction_bit;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_out <= next_pin_out;
      pin_oe <= next_pin_oe;
    end
  end
endmodule : tmr8_pin_mux

// ---- rtl/tmr8_core.sv ----
// 8-bit timer waveform unit with APB registers and port pin override.
// Assumes timer_tick is a one-cycle enable from a prescaler on pclk.
//
// Design decisions made here: the register addresses and the APB slave port.
`include "tmr8_cfg.svh"

module tmr8_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic timer_tick,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic pin_out,
  output logic pin_oe
);
  tmr8_pkg::tmr8_wave_t waveform_mode;
  tmr8_pkg::tmr8_com_t compare_output_mode;
  logic [7:0] counter_value;
  logic [7:0] compare_value;
  logic [7:0] compare_buffer;
  logic compare_output_state;
  logic overflow_flag;
  logic compare_flag;
  logic match_pending;
  logic match_block;
  logic port_value;
  logic pin_direction_bit;

  tmr8_pkg::tmr8_wave_t next_waveform_mode;
  tmr8_pkg::tmr8_com_t next_compare_output_mode;
  logic [7:0] next_counter_value;
  logic [7:0] next_compare_value;
  logic [7:0] next_compare_buffer;
  logic next_compare_output_state;
  logic next_overflow_flag;
  logic next_compare_flag;
  logic next_match_pending;
  logic next_match_block;
  logic next_port_value;
  logic next_pin_direction_bit;
  logic [31:0] next_prdata;

  function automatic logic is_pwm(input tmr8_pkg::tmr8_wave_t m);
    return m == tmr8_pkg::TMR8_PHASE || m == tmr8_pkg::TMR8_FAST;
  endfunction : is_pwm

  function automatic logic oc_apply(input tmr8_pkg::tmr8_com_t c, input logic oc);
    logic r;
    r = oc;
    unique case (c)
      tmr8_pkg::TMR8_COM_OFF: r = oc;
      tmr8_pkg::TMR8_COM_TOGGLE: r = ~oc;
      tmr8_pkg::TMR8_COM_CLEAR: r = 1'b0;
      tmr8_pkg::TMR8_COM_SET: r = 1'b1;
    endcase
    return r;
  endfunction : oc_apply

  logic access;
  logic wr_ctrl;
  logic wr_count;
  logic wr_compare;
  logic wr_flags;
  logic wr_port;
  logic mapped;
  logic counts;
  logic equal;
  logic match_ok;
  logic top_tick;
  logic force_ok;
  tmr8_pkg::tmr8_wave_t wr_mode;
  tmr8_pkg::tmr8_com_t wr_com;

  assign access = psel & penable;
  assign mapped = (paddr == `TMR8_OFF_CTRL) || (paddr == `TMR8_OFF_COUNT) || (paddr == `TMR8_OFF_COMPARE)
                  || (paddr == `TMR8_OFF_FLAGS) || (paddr == `TMR8_OFF_PORT);
  assign wr_ctrl = access & pwrite & (paddr == `TMR8_OFF_CTRL);
  assign wr_count = access & pwrite & (paddr == `TMR8_OFF_COUNT);
  assign wr_compare = access & pwrite & (paddr == `TMR8_OFF_COMPARE);
  assign wr_flags = access & pwrite & (paddr == `TMR8_OFF_FLAGS);
  assign wr_port = access & pwrite & (paddr == `TMR8_OFF_PORT);
  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  assign wr_mode = tmr8_pkg::tmr8_wave_t'(pwdata[`TMR8_CTRL_WMODE_LSB +: 2]);
  assign wr_com = tmr8_pkg::tmr8_com_t'(pwdata[`TMR8_CTRL_COM_LSB +: 2]);
  // Dual-slope mode is not built here; the counter holds in it
  assign counts = timer_tick & (waveform_mode != tmr8_pkg::TMR8_PHASE);
  assign equal = counter_value == compare_value;
  assign match_ok = counts & equal & ~match_block;
  assign top_tick = counts & (counter_value == `TMR8_MAX);
  // Force uses the mode and action carried by the same write
  assign force_ok = wr_ctrl & pwdata[`TMR8_CTRL_FORCE_BIT] & ~is_pwm(wr_mode);

  // Counter sequencing
  always_comb begin
    next_counter_value = counter_value;
    next_match_block = match_block;
    if (counts) begin
      unique case (waveform_mode)
        tmr8_pkg::TMR8_NORMAL: next_counter_value = counter_value + 8'h01;
        tmr8_pkg::TMR8_CTC: next_counter_value = match_ok ? `TMR8_BOTTOM : counter_value + 8'h01;
        tmr8_pkg::TMR8_FAST: next_counter_value = counter_value + 8'h01;
        tmr8_pkg::TMR8_PHASE: next_counter_value = counter_value;
      endcase
    end
    if (timer_tick) begin
      next_match_block = 1'b0;
    end
    // Software write beats any count or clear
    if (wr_count) begin
      next_counter_value = pwdata[7:0];
      next_match_block = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_value <= `TMR8_RST_COUNT;
      match_block <= 1'b0;
    end else begin
      counter_value <= next_counter_value;
      match_block <= next_match_block;
    end
  end

  // Compare value and its buffer
  always_comb begin
    next_compare_buffer = compare_buffer;
    next_compare_value = compare_value;
    if (is_pwm(waveform_mode) && top_tick) begin
      next_compare_value = compare_buffer;
    end
    if (wr_compare) begin
      next_compare_buffer = pwdata[7:0];
      if (!is_pwm(waveform_mode)) begin
        next_compare_value = pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_value <= `TMR8_RST_COMPARE;
      compare_buffer <= `TMR8_RST_COMPARE;
    end else begin
      compare_value <= next_compare_value;
      compare_buffer <= next_compare_buffer;
    end
  end

  // Flags: a set in the same cycle as a clear wins
  always_comb begin
    next_match_pending = timer_tick ? match_ok : match_pending;
    next_overflow_flag = (overflow_flag & ~(wr_flags & pwdata[`TMR8_FLAGS_OVF_BIT])) | top_tick;
    next_compare_flag = (compare_flag & ~(wr_flags & pwdata[`TMR8_FLAGS_CMP_BIT]))
                        | (timer_tick & match_pending);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_pending <= 1'b0;
      overflow_flag <= 1'b0;
      compare_flag <= 1'b0;
    end else begin
      match_pending <= next_match_pending;
      overflow_flag <= next_overflow_flag;
      compare_flag <= next_compare_flag;
    end
  end

  // Compare output state; compare output mode never touches counting
  always_comb begin
    next_compare_output_state = compare_output_state;
    if (waveform_mode == tmr8_pkg::TMR8_FAST) begin
      if (match_ok) begin
        next_compare_output_state = oc_apply(compare_output_mode, compare_output_state);
      end
      // Bottom wins so compare at max gives a steady level
      if (top_tick && compare_output_mode == tmr8_pkg::TMR8_COM_CLEAR) begin
        next_compare_output_state = 1'b1;
      end
      if (top_tick && compare_output_mode == tmr8_pkg::TMR8_COM_SET) begin
        next_compare_output_state = 1'b0;
      end
    end else if (!is_pwm(waveform_mode)) begin
      if (force_ok) begin
        next_compare_output_state = oc_apply(wr_com, compare_output_state);
      end else if (match_ok) begin
        next_compare_output_state = oc_apply(compare_output_mode, compare_output_state);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_output_state <= 1'b0;
    end else begin
      compare_output_state <= next_compare_output_state;
    end
  end

  // Control, port registers and read data
  always_comb begin
    next_waveform_mode = waveform_mode;
    next_compare_output_mode = compare_output_mode;
    next_port_value = port_value;
    next_pin_direction_bit = pin_direction_bit;
    next_prdata = prdata;
    if (wr_ctrl) begin
      next_waveform_mode = wr_mode;
      next_compare_output_mode = wr_com;
    end
    if (wr_port) begin
      next_port_value = pwdata[`TMR8_PORT_VAL_BIT];
      next_pin_direction_bit = pwdata[`TMR8_PORT_DIR_BIT];
    end
    // Read data captured in the setup phase; force bit reads zero
    if (psel && !penable) begin
      next_prdata = 32'h0000_0000;
      unique case (paddr)
        `TMR8_OFF_CTRL: begin
          next_prdata[`TMR8_CTRL_WMODE_LSB +: 2] = waveform_mode;
          next_prdata[`TMR8_CTRL_COM_LSB +: 2] = compare_output_mode;
        end
        `TMR8_OFF_COUNT: next_prdata[7:0] = counter_value;
        `TMR8_OFF_COMPARE: next_prdata[7:0] = compare_buffer;
        `TMR8_OFF_FLAGS: begin
          next_prdata[`TMR8_FLAGS_OVF_BIT] = overflow_flag;
          next_prdata[`TMR8_FLAGS_CMP_BIT] = compare_flag;
        end
        `TMR8_OFF_PORT: begin
          next_prdata[`TMR8_PORT_VAL_BIT] = port_value;
          next_prdata[`TMR8_PORT_DIR_BIT] = pin_direction_bit;
          next_prdata[`TMR8_PORT_OC_BIT] = compare_output_state;
        end
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      waveform_mode <= tmr8_pkg::TMR8_NORMAL;
      compare_output_mode <= tmr8_pkg::TMR8_COM_OFF;
      port_value <= 1'b0;
      pin_direction_bit <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      waveform_mode <= next_waveform_mode;
      compare_output_mode <= next_compare_output_mode;
      port_value <= next_port_value;
      pin_direction_bit <= next_pin_direction_bit;
      prdata <= next_prdata;
    end
  end

  tmr8_pin_mux u_pin_mux (
    .pclk(pclk),
    .presetn(presetn),
    .compare_output_mode(compare_output_mode),
    .compare_output_state(compare_output_state),
    .port_value(port_value),
    .pin_direction_bit(pin_direction_bit),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
  );

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_count_write_then_tick;
    wr_count ##1 (timer_tick && !wr_count);
  endsequence

  sequence s_fast_bottom;
    (waveform_mode == tmr8_pkg::TMR8_FAST) && top_tick && !wr_ctrl;
  endsequence

  AST_OVF_AT_MAX: assert property (top_tick |=> overflow_flag)
    else $error("overflow flag not set after max");

  AST_NORMAL_INC: assert property ((waveform_mode == tmr8_pkg::TMR8_NORMAL) && timer_tick && !wr_count
    |=> counter_value == $past(counter_value) + 8'h01)
    else $error("normal mode did not increment");

  AST_CTC_CLEAR: assert property ((waveform_mode == tmr8_pkg::TMR8_CTC) && match_ok && !wr_count
    |=> counter_value == `TMR8_BOTTOM)
    else $error("clear-on-match did not clear counter");

  AST_FLAG_NEXT_TICK: assert property (timer_tick && match_ok ##1 (!timer_tick)[*1] ##1 timer_tick
    |=> compare_flag)
    else $error("compare flag missing one tick after match");

  AST_WRITE_BLOCKS: assert property (s_count_write_then_tick |=> !match_pending)
    else $error("match not blocked after counter write");

  AST_CTC_TOGGLE: assert property ((waveform_mode == tmr8_pkg::TMR8_CTC) && match_ok && !wr_ctrl
    && compare_output_mode == tmr8_pkg::TMR8_COM_TOGGLE
    |=> compare_output_state != $past(compare_output_state))
    else $error("toggle mode did not toggle");

  AST_FORCE_NO_COUNT: assert property (force_ok && !timer_tick
    |=> counter_value == $past(counter_value) && compare_flag == $past(compare_flag))
    else $error("force changed counter or flag");

  AST_FORCE_SET: assert property (force_ok && wr_com == tmr8_pkg::TMR8_COM_SET |=> compare_output_state)
    else $error("force set did not set output");

  AST_FAST_BOTTOM: assert property ((s_fast_bottom and (compare_output_mode == tmr8_pkg::TMR8_COM_CLEAR))
    |=> compare_output_state ##1 pin_out)
    else $error("fast mode bottom did not set output");

  AST_PWM_BUFFERED: assert property ((waveform_mode == tmr8_pkg::TMR8_FAST) && wr_compare && !top_tick
    |=> compare_value == $past(compare_value))
    else $error("compare value updated outside top");

  AST_OVERRIDE: assert property ($past(compare_output_mode) != tmr8_pkg::TMR8_COM_OFF
    |-> pin_out == $past(compare_output_state))
    else $error("pin not driven from compare output state");

  AST_DIRECTION: assert property (!pin_direction_bit |=> !pin_oe)
    else $error("pin enabled while direction is input");
endmodule : tmr8_core

// ---- verif/tmr8_port_pin.sv ----
// Port pin model: resolves the pad level from the timer's drive.
// Assumes an external pull on the pad whenever nobody drives it.
module tmr8_port_pin #(
  parameter logic PULL_LEVEL = 1'b1
) (
  input wire logic pin_out,
  input wire logic pin_oe,
  output logic pin_level
);
  // Released pad settles to the pull, never keeps the last driven value
  assign pin_level = pin_oe ? pin_out : PULL_LEVEL;
endmodule : tmr8_port_pin

// ---- verif/testbench.sv ----
// Self-checking bench of the timer core: APB master, tick source, pin model.
// Assumes the offsets of tmr8_cfg.svh and a zero-wait APB slave.
`include "tmr8_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic PULL = 1'b1;
  logic pclk, presetn, psel, penable, pwrite, timer_tick;
  logic [7:0] paddr;
  logic [7:0] c;
  logic [31:0] pwdata, prdata, seed;
  logic pready, pslverr, pin_out, pin_oe, pin_level, o;
  logic [34:0] e;
  logic [34:0] expq[$];
  int bad_count, n_checks;

  tmr8_core i_tmr8_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .timer_tick(timer_tick), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe));
  tmr8_port_pin #(.PULL_LEVEL(PULL)) i_tmr8_port_pin (.pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic miss(input logic [32:0] x, input logic [32:0] g);
    bad_count++;
    $display("MISMATCH t=%0t exp=%h got=%h", $time, x, g);
  endtask : miss

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  // Read results land only in the access cycle, so the watcher samples there
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0 && expq.size() > 0) begin
      e = expq.pop_front();
      n_checks++;
      if ({pslverr, prdata} !== e[32:0]) miss(e[32:0], {pslverr, prdata});
      if (e[34]) begin
        n_checks++;
        if (pin_level !== e[33]) miss({32'h0, e[33]}, {32'h0, pin_level});
      end
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      miss(33'h1, {32'h0, pready});
      print_verdict();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    expq.push_back({3'b000, x});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic rp(input logic [31:0] x, input logic p);
    expq.push_back({1'b1, p, 1'b0, x});
    apb(1'b0, `TMR8_OFF_PORT, 32'h0);
  endtask : rp

  task automatic ctl(input logic [1:0] m, input logic [1:0] cm, input logic f);
    wr(`TMR8_OFF_CTRL, {27'h0, f, cm, m});
  endtask : ctl

  // Random gaps between ticks; the counter must not care about spacing
  task automatic tk(input int n);
    repeat (n) begin
      @(posedge pclk);
      timer_tick <= 1'b1;
      @(posedge pclk);
      timer_tick <= 1'b0;
      repeat (rnd() % 3) @(posedge pclk);
    end
  endtask : tk

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    timer_tick = 1'b0;
    seed = 32'h00017369;
    bad_count = 0;
    n_checks = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(`TMR8_OFF_CTRL, 32'h0);
    rd(`TMR8_OFF_COUNT, 32'h0);
    rd(`TMR8_OFF_FLAGS, 32'h0);
    rp(32'h0, PULL);
    expq.push_back({3'b001, 32'h0});
    apb(1'b0, 8'h14, 32'h0);
    done("reset");
    wr(`TMR8_OFF_COMPARE, 32'h80);
    rd(`TMR8_OFF_COMPARE, 32'h80);
    wr(`TMR8_OFF_COUNT, 32'hfd);
    tk(2);
    rd(`TMR8_OFF_COUNT, 32'hff);
    rd(`TMR8_OFF_FLAGS, 32'h0);
    tk(1);
    rd(`TMR8_OFF_COUNT, 32'h0);
    rd(`TMR8_OFF_FLAGS, 32'h1);
    tk(3);
    rd(`TMR8_OFF_FLAGS, 32'h1);
    wr(`TMR8_OFF_FLAGS, 32'h1);
    wr(`TMR8_OFF_COUNT, 32'h7e);
    tk(2);
    rd(`TMR8_OFF_FLAGS, 32'h0);
    tk(2);
    rd(`TMR8_OFF_FLAGS, 32'h2);
    wr(`TMR8_OFF_FLAGS, 32'h2);
    wr(`TMR8_OFF_COUNT, 32'h80);
    tk(4);
    rd(`TMR8_OFF_FLAGS, 32'h0);
    done("normal");
    wr(`TMR8_OFF_PORT, 32'h1);
    ctl(2'd0, 2'd2, 1'b1);
    rp(32'h1, PULL);
    for (int k = 1; k < 4; k++) begin
      ctl(2'd0, k[1:0], 1'b1);
      rp({29'h0, k != 2, 2'b01}, PULL);
    end
    ctl(2'd0, 2'd0, 1'b1);
    rp(32'h5, PULL);
    rd(`TMR8_OFF_FLAGS, 32'h0);
    rd(`TMR8_OFF_COUNT, 32'h84);
    wr(`TMR8_OFF_PORT, 32'h3);
    rp(32'h7, 1'b1);
    wr(`TMR8_OFF_PORT, 32'h2);
    rp(32'h6, 1'b0);
    ctl(2'd0, 2'd3, 1'b0);
    rp(32'h6, 1'b1);
    ctl(2'd0, 2'd2, 1'b1);
    rp(32'h2, 1'b0);
    done("force");
    c = 8'h01 + 8'(rnd() % 7);
    o = 1'b0;
    ctl(2'd2, 2'd1, 1'b0);
    wr(`TMR8_OFF_COMPARE, {24'h0, c});
    wr(`TMR8_OFF_COUNT, 32'h0);
    repeat (2) begin
      tk(int'(c) + 1);
      o = ~o;
      rd(`TMR8_OFF_COUNT, 32'h0);
      rp({29'h0, o, 2'b10}, o);
    end
    tk(1);
    wr(`TMR8_OFF_FLAGS, 32'h3);
    wr(`TMR8_OFF_COUNT, 32'hfe);
    tk(2);
    rd(`TMR8_OFF_COUNT, 32'h0);
    rd(`TMR8_OFF_FLAGS, 32'h1);
    done("clear on match");
    ctl(2'd2, 2'd3, 1'b1);
    ctl(2'd3, 2'd2, 1'b0);
    wr(`TMR8_OFF_COUNT, 32'h0);
    wr(`TMR8_OFF_COMPARE, 32'h80);
    rd(`TMR8_OFF_COMPARE, 32'h80);
    tk(10);
    rp(32'h2, 1'b0);
    wr(`TMR8_OFF_FLAGS, 32'h3);
    wr(`TMR8_OFF_COUNT, 32'hfe);
    tk(1);
    rd(`TMR8_OFF_COUNT, 32'hff);
    tk(1);
    rd(`TMR8_OFF_COUNT, 32'h0);
    rd(`TMR8_OFF_FLAGS, 32'h1);
    rp(32'h6, 1'b1);
    tk(128);
    rp(32'h6, 1'b1);
    tk(1);
    rp(32'h2, 1'b0);
    ctl(2'd3, 2'd3, 1'b0);
    tk(127);
    rp(32'h2, 1'b0);
    tk(129);
    rp(32'h6, 1'b1);
    ctl(2'd3, 2'd1, 1'b0);
    rp(32'h6, 1'b1);
    tk(127);
    rp(32'h6, 1'b1);
    tk(129);
    rp(32'h2, 1'b0);
    wr(`TMR8_OFF_COMPARE, 32'h0);
    ctl(2'd3, 2'd2, 1'b0);
    tk(127);
    rp(32'h6, 1'b1);
    tk(1);
    rp(32'h2, 1'b0);
    wr(`TMR8_OFF_COMPARE, 32'hff);
    tk(255);
    repeat (5) begin
      rp(32'h6, 1'b1);
      tk(64);
    end
    done("fast pwm");
    print_verdict();
  end
endmodule : testbench
